/* rtl/scitb_defines.svh */
`ifndef SCITB_DEFINES_SVH
`define SCITB_DEFINES_SVH

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define SCITB_CLK_HZ 20000000
`define SCITB_MS_TIME_US 1000
`define SCITB_MS_CYCLES ((`SCITB_CLK_HZ / 1000000) * `SCITB_MS_TIME_US)
`define SCITB_BAUD 115200
`define SCITB_BAUD_CYCLES (`SCITB_CLK_HZ / `SCITB_BAUD)
`define SCITB_SCK_HALF 5

// ----------------------------------------------------------------------
// Targets and lines
// ----------------------------------------------------------------------
`define SCITB_SLOT_MAX 3
`define SCITB_LINES_PER_SLOT 8

// ----------------------------------------------------------------------
// Characters and command names (last four letters, lower case)
// ----------------------------------------------------------------------
`define SCITB_CH_OPEN 8'h28
`define SCITB_CH_CLOSE 8'h29
`define SCITB_CH_COMMA 8'h2c
`define SCITB_CH_X 8'h78
`define SCITB_CH_CR 8'h0d
`define SCITB_CH_LF 8'h0a
`define SCITB_CH_ERR 8'h3f
`define SCITB_NAME_HELP 32'h68656c70
`define SCITB_NAME_DELAY 32'h656c6179
`define SCITB_NAME_IOR 32'h00696f72
`define SCITB_NAME_IOW 32'h00696f77
`define SCITB_NAME_IOP 32'h00696f70
`define SCITB_NAME_IOWT 32'h696f7774
`define SCITB_NAME_SPI 32'h00737069
`define SCITB_NAME_SPIS 32'h73706973
`define SCITB_NAME_SPIR 32'h73706972

`endif

/* rtl/scitb_pkg.sv */
package scitb_pkg;

    typedef enum logic [2:0] {
        ST_NAME = 3'h0,
        ST_ARGS = 3'h1,
        ST_EXEC = 3'h2,
        ST_WAIT_MS = 3'h3,
        ST_SPI = 3'h4,
        ST_IOWAIT = 3'h5,
        ST_REPLY = 3'h6
    } scitb_state_t;

    typedef enum logic [3:0] {
        CMD_NONE = 4'h0,
        CMD_HELP = 4'h1,
        CMD_DELAY = 4'h2,
        CMD_IOR = 4'h3,
        CMD_IOW = 4'h4,
        CMD_IOP = 4'h5,
        CMD_IOWT = 4'h6,
        CMD_SPI = 4'h7,
        CMD_SPIS = 4'h8,
        CMD_SPIR = 4'h9
    } scitb_cmd_t;

    typedef struct packed {
        logic start;
        logic [1:0] slot;
        logic wide;
        logic [31:0] word;
    } scitb_spi_req_t;

    typedef struct packed {
        logic sclk;
        logic mosi;
        logic [3:0] cs_n;
    } scitb_spi_pins_t;

    typedef struct packed {
        logic miso_m;
        logic miso_s;
        logic busy;
        logic wide;
        logic [7:0] div;
        logic [5:0] bits;
        logic [31:0] sh;
        logic [31:0] rx;
        logic [31:0] rx_out;
        logic done;
        scitb_spi_pins_t pins;
    } scitb_spi_st_t;

    typedef struct packed {
        logic rx_m;
        logic rx_s;
        logic [7:0] rx_cnt;
        logic [3:0] rx_bit;
        logic [7:0] rx_sh;
        logic rx_busy;
        logic [7:0] tx_cnt;
        logic [3:0] tx_bit;
        logic [8:0] tx_sh;
        logic tx_busy;
        logic txd;
        logic [31:0] io_m;
        logic [31:0] io_s;
        logic [31:0] io_out;
        logic [31:0] io_oe;
        logic [23:0] ms_div;
        scitb_state_t state;
        scitb_cmd_t cmd;
        logic [31:0] name;
        logic [2:0] argc;
        logic [4:0][31:0] arg;
        logic [31:0] cur;
        logic dig;
        logic [31:0] ms_left;
        logic [31:0] ret;
        logic rep_err;
        logic [3:0] rep_idx;
        logic step;
        logic spi_wait;
        logic wd_run;
        logic wd_due;
        logic [15:0] wd_ms;
        logic [31:0] last_rx;
    } scitb_st_t;

endpackage

/* rtl/scitb_spi.sv */
`timescale 1ns/1ps
`include "scitb_defines.svh"

module scitb_spi
(
    input wire logic ref_clk_i,
    input wire logic reset_i,
    input scitb_pkg::scitb_spi_req_t req_i,
    input wire logic miso_i,
    output scitb_pkg::scitb_spi_pins_t pins_o,
    output logic busy_o,
    output logic done_o,
    output logic [31:0] rx_o
);

    scitb_pkg::scitb_spi_st_t s;
    scitb_pkg::scitb_spi_st_t n;
    logic half;

    // ------------------------------------------------------------------
    // Mode 0 shifter: sample on the rising edge, shift on the falling.
    // ------------------------------------------------------------------
    always_comb
    begin
        n = s;
        n.done = 1'b0;
        n.miso_m = miso_i;
        n.miso_s = s.miso_m;
        half = (s.div == 8'(`SCITB_SCK_HALF - 1));
        if (!s.busy)
        begin
            if (req_i.start)
            begin
                n.busy = 1'b1;
                n.wide = req_i.wide;
                n.div = 8'h00;
                n.bits = req_i.wide ? 6'h20 : 6'h10;
                n.sh = req_i.wide ? req_i.word : {req_i.word[15:0], 16'h0000};
                n.rx = 32'h00000000;
                n.pins.cs_n = ~(4'h1 << req_i.slot);
                n.pins.mosi = req_i.wide ? req_i.word[31] : req_i.word[15];
            end
        end
        else
        begin
            n.div = half ? 8'h00 : s.div + 8'h01;
            if (half && !s.pins.sclk)
            begin
                n.pins.sclk = 1'b1;
                n.rx = {s.rx[30:0], s.miso_s};
            end
            else if (half)
            begin
                n.pins.sclk = 1'b0;
                n.bits = s.bits - 6'h01;
                n.sh = {s.sh[30:0], 1'b0};
                n.pins.mosi = s.sh[30];
                if (s.bits == 6'h01)
                begin
                    n.busy = 1'b0;
                    n.done = 1'b1;
                    n.rx_out = s.rx;
                    n.pins.cs_n = 4'hf;
                    n.pins.mosi = 1'b0;
                end
            end
        end
    end

    // State register; chip selects idle high.
    always_ff @(posedge ref_clk_i)
    begin
        if (reset_i)
        begin
            s <= '0;
            s.pins.cs_n <= 4'hf;
        end
        else
        begin
            s <= n;
        end
    end

    assign pins_o = s.pins;
    assign busy_o = s.busy;
    assign done_o = s.done;
    assign rx_o = s.rx_out;

endmodule

/* rtl/scitb_top.sv */
`timescale 1ns/1ps
`include "scitb_defines.svh"

// Behaviour
// - Take text commands over UART, execute them.
// - Slot 0 connection board, 1 to 3 boards.
// - Help replies zero.
// - Delay waits milliseconds, 1 upward, returns count.
// - I/O read returns present line level.
// - I/O write drives level, returns level.
// - Pulse holds level, then inverts, returns line.
// - I/O wait blocks until level, returns level.
// - Single SPI sends word, returns previous response.
// - Watchdog frames may slip between host transfers.
// - Sequence sends two words with delay between.
// - SPI read back to back, no watchdog.
module scitb_top
#(
    parameter int MS_CYCLES = `SCITB_MS_CYCLES,
    parameter int BAUD_CYCLES = `SCITB_BAUD_CYCLES
)
(
    input wire logic ref_clk_i,
    input wire logic reset_i,
    input wire logic uart_rxd_i,
    output logic uart_txd_o,
    input wire logic [31:0] io_in_i,
    output logic [31:0] io_out_o,
    output logic [31:0] io_oe_o,
    input wire logic [3:0] spi_wide_i,
    input wire logic spi_miso_i,
    output scitb_pkg::scitb_spi_pins_t spi_pins_o,
    input wire logic wd_enable_i,
    input wire logic [15:0] wd_period_i,
    input wire logic [31:0] wd_word_i,
    output logic cmd_busy_o
);

    scitb_pkg::scitb_st_t s;
    scitb_pkg::scitb_st_t n;
    scitb_pkg::scitb_spi_req_t req;
    logic spi_busy;
    logic spi_done;
    logic [31:0] spi_rx;
    logic ms_tick;
    logic byte_v;
    logic [7:0] rb;
    logic [4:0] hx;
    logic [4:0] line;
    logic lvl;
    logic slot_ok;
    logic line_ok;
    logic host_go;
    logic wd_go;
    logic no_wd;

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------

    // Returns {valid, nibble} for one hex character.
    function automatic logic [4:0] hex_val(input logic [7:0] c);
        logic [4:0] r;
        r = 5'h00;
        if (c >= 8'h30 && c <= 8'h39)
            r = {1'b1, 4'(c - 8'h30)};
        else if (c >= 8'h61 && c <= 8'h66)
            r = {1'b1, 4'(c - 8'h57)};
        else if (c >= 8'h41 && c <= 8'h46)
            r = {1'b1, 4'(c - 8'h37)};
        return r;
    endfunction

    // Turns one nibble into a lower-case hex character.
    function automatic logic [7:0] hex_chr(input logic [3:0] v);
        return (v < 4'ha) ? 8'h30 + {4'h0, v} : 8'h57 + {4'h0, v};
    endfunction

    // Maps the last four name letters onto a command code.
    function automatic scitb_pkg::scitb_cmd_t cmd_of(input logic [31:0] nm);
        scitb_pkg::scitb_cmd_t c;
        c = scitb_pkg::CMD_NONE;
        unique case (nm)
            `SCITB_NAME_HELP: c = scitb_pkg::CMD_HELP;
            `SCITB_NAME_DELAY: c = scitb_pkg::CMD_DELAY;
            `SCITB_NAME_IOR: c = scitb_pkg::CMD_IOR;
            `SCITB_NAME_IOW: c = scitb_pkg::CMD_IOW;
            `SCITB_NAME_IOP: c = scitb_pkg::CMD_IOP;
            `SCITB_NAME_IOWT: c = scitb_pkg::CMD_IOWT;
            `SCITB_NAME_SPI: c = scitb_pkg::CMD_SPI;
            `SCITB_NAME_SPIS: c = scitb_pkg::CMD_SPIS;
            `SCITB_NAME_SPIR: c = scitb_pkg::CMD_SPIR;
            default: c = scitb_pkg::CMD_NONE;
        endcase
        return c;
    endfunction

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb
    begin
        n = s;
        byte_v = 1'b0;
        rb = s.rx_sh;
        host_go = 1'b0;
        wd_go = 1'b0;
        // Two-stage synchronisers for the pins.
        n.rx_m = uart_rxd_i;
        n.rx_s = s.rx_m;
        n.io_m = io_in_i;
        n.io_s = s.io_m;
        // Millisecond enable from the clock divider.
        ms_tick = (s.ms_div == 24'(MS_CYCLES - 1));
        n.ms_div = ms_tick ? 24'h000000 : s.ms_div + 24'h000001;
        line = {s.arg[0][1:0], s.arg[1][2:0]};
        lvl = s.io_oe[line] ? s.io_out[line] : s.io_s[line];
        slot_ok = (s.arg[0] <= 32'(`SCITB_SLOT_MAX));
        line_ok = (s.arg[1] < 32'(`SCITB_LINES_PER_SLOT));
        hx = hex_val(s.rx_sh);

        // UART receiver, sampled at mid-bit.
        if (!s.rx_busy)
        begin
            if (!s.rx_s)
            begin
                n.rx_busy = 1'b1;
                n.rx_bit = 4'h0;
                n.rx_cnt = 8'(BAUD_CYCLES / 2);
            end
        end
        else if (s.rx_cnt != 8'h00)
            n.rx_cnt = s.rx_cnt - 8'h01;
        else
        begin
            n.rx_cnt = 8'(BAUD_CYCLES - 1);
            n.rx_bit = s.rx_bit + 4'h1;
            if (s.rx_bit == 4'h0)
                n.rx_busy = ~s.rx_s;
            else if (s.rx_bit < 4'h9)
                n.rx_sh = {s.rx_s, s.rx_sh[7:1]};
            else
            begin
                n.rx_busy = 1'b0;
                byte_v = s.rx_s;
            end
        end

        // UART transmitter: start, eight data bits, stop.
        if (s.tx_busy)
        begin
            if (s.tx_cnt != 8'h00)
                n.tx_cnt = s.tx_cnt - 8'h01;
            else if (s.tx_bit == 4'h9)
                n.tx_busy = 1'b0;
            else
            begin
                n.tx_cnt = 8'(BAUD_CYCLES - 1);
                n.txd = s.tx_sh[0];
                n.tx_sh = {1'b1, s.tx_sh[8:1]};
                n.tx_bit = s.tx_bit + 4'h1;
            end
        end

        // Command parser and executor.
        unique case (s.state)
            scitb_pkg::ST_NAME:
            begin
                if (byte_v && rb == `SCITB_CH_OPEN)
                begin
                    n.cmd = cmd_of(s.name);
                    n.state = scitb_pkg::ST_ARGS;
                    n.argc = 3'h0;
                    n.cur = 32'h00000000;
                    n.dig = 1'b0;
                end
                else if (byte_v && rb >= 8'h61 && rb <= 8'h7a)
                    n.name = {s.name[23:0], rb};
                else if (byte_v)
                    n.name = 32'h00000000;
            end
            scitb_pkg::ST_ARGS:
            begin
                if (byte_v && hx[4])
                begin
                    n.cur = {s.cur[27:0], hx[3:0]};
                    n.dig = 1'b1;
                end
                else if (byte_v && rb == `SCITB_CH_X)
                    n.cur = 32'h00000000;
                else if (byte_v && (rb == `SCITB_CH_COMMA ||
                         rb == `SCITB_CH_CLOSE))
                begin
                    if (s.dig && s.argc < 3'h5)
                    begin
                        n.arg[s.argc] = s.cur;
                        n.argc = s.argc + 3'h1;
                    end
                    n.cur = 32'h00000000;
                    n.dig = 1'b0;
                    if (rb == `SCITB_CH_CLOSE)
                        n.state = scitb_pkg::ST_EXEC;
                end
            end
            scitb_pkg::ST_EXEC:
            begin
                n.state = scitb_pkg::ST_REPLY;
                n.rep_idx = 4'h0;
                n.rep_err = 1'b1;
                n.step = 1'b0;
                unique case (s.cmd)
                    scitb_pkg::CMD_HELP:
                    begin
                        n.ret = 32'h00000000;
                        n.rep_err = 1'b0;
                    end
                    scitb_pkg::CMD_DELAY:
                        if (s.argc == 3'h1 && s.arg[0] != 32'h00000000)
                        begin
                            n.ret = s.arg[0];
                            n.ms_left = s.arg[0];
                            n.rep_err = 1'b0;
                            n.state = scitb_pkg::ST_WAIT_MS;
                        end
                    scitb_pkg::CMD_IOR:
                        if (s.argc == 3'h2 && slot_ok && line_ok)
                        begin
                            n.ret = {31'h00000000, lvl};
                            n.rep_err = 1'b0;
                        end
                    scitb_pkg::CMD_IOW:
                        if (s.argc == 3'h3 && slot_ok && line_ok &&
                            s.arg[2] <= 32'h00000001)
                        begin
                            n.io_out[line] = s.arg[2][0];
                            n.io_oe[line] = 1'b1;
                            n.ret = s.arg[2];
                            n.rep_err = 1'b0;
                        end
                    scitb_pkg::CMD_IOP:
                        if (s.argc == 3'h4 && slot_ok && line_ok &&
                            s.arg[2] <= 32'h00000001 &&
                            s.arg[3] != 32'h00000000)
                        begin
                            n.io_out[line] = s.arg[2][0];
                            n.io_oe[line] = 1'b1;
                            n.ms_left = s.arg[3];
                            n.ret = s.arg[1];
                            n.rep_err = 1'b0;
                            n.state = scitb_pkg::ST_WAIT_MS;
                        end
                    scitb_pkg::CMD_IOWT:
                        if (s.argc == 3'h3 && slot_ok && line_ok &&
                            s.arg[2] <= 32'h00000001)
                        begin
                            n.ret = s.arg[2];
                            n.rep_err = 1'b0;
                            n.state = scitb_pkg::ST_IOWAIT;
                        end
                    scitb_pkg::CMD_SPI, scitb_pkg::CMD_SPIS,
                    scitb_pkg::CMD_SPIR:
                        if (slot_ok && s.arg[1] == 32'h00000000 &&
                            ((s.cmd == scitb_pkg::CMD_SPI && s.argc == 3'h3) ||
                             (s.cmd == scitb_pkg::CMD_SPIR && s.argc == 3'h4) ||
                             (s.cmd == scitb_pkg::CMD_SPIS && s.argc == 3'h5 &&
                              s.arg[4] != 32'h00000000)))
                        begin
                            n.rep_err = 1'b0;
                            n.state = scitb_pkg::ST_SPI;
                        end
                    default:
                        n.rep_err = 1'b1;
                endcase
            end
            scitb_pkg::ST_WAIT_MS:
            begin
                if (ms_tick && s.ms_left == 32'h00000001)
                begin
                    n.state = scitb_pkg::ST_REPLY;
                    if (s.cmd == scitb_pkg::CMD_IOP)
                        n.io_out[line] = ~s.arg[2][0];
                    else if (s.cmd == scitb_pkg::CMD_SPIS)
                        n.state = scitb_pkg::ST_SPI;
                end
                else if (ms_tick)
                    n.ms_left = s.ms_left - 32'h00000001;
            end
            scitb_pkg::ST_SPI:
            begin
                if (!s.spi_wait && !spi_busy && !s.wd_run)
                begin
                    host_go = 1'b1;
                    n.spi_wait = 1'b1;
                    if (s.cmd != scitb_pkg::CMD_SPIR)
                        n.ret = s.last_rx;
                end
                else if (s.spi_wait && spi_done && !s.wd_run)
                begin
                    n.spi_wait = 1'b0;
                    n.step = 1'b1;
                    if (s.cmd == scitb_pkg::CMD_SPI || s.step)
                        n.state = scitb_pkg::ST_REPLY;
                    else if (s.cmd == scitb_pkg::CMD_SPIS)
                    begin
                        n.ms_left = s.arg[4];
                        n.state = scitb_pkg::ST_WAIT_MS;
                    end
                    if (s.cmd == scitb_pkg::CMD_SPIR && s.step)
                        n.ret = spi_rx;
                end
            end
            scitb_pkg::ST_IOWAIT:
                if (lvl == s.arg[2][0])
                    n.state = scitb_pkg::ST_REPLY;
            scitb_pkg::ST_REPLY:
            begin
                // Busy is held until the last stop bit has gone out.
                if (!s.tx_busy && ((s.rep_err && s.rep_idx == 4'h3) ||
                    s.rep_idx == 4'ha))
                begin
                    n.state = scitb_pkg::ST_NAME;
                    n.name = 32'h00000000;
                end
                else if (!s.tx_busy)
                begin
                    n.tx_busy = 1'b1;
                    n.tx_bit = 4'h0;
                    n.tx_cnt = 8'(BAUD_CYCLES - 1);
                    n.txd = 1'b0;
                    n.rep_idx = s.rep_idx + 4'h1;
                    if (s.rep_err)
                        n.tx_sh = {1'b1, (s.rep_idx == 4'h0) ? `SCITB_CH_ERR :
                                   (s.rep_idx == 4'h1) ? `SCITB_CH_CR :
                                   `SCITB_CH_LF};
                    else
                        n.tx_sh = {1'b1, (s.rep_idx < 4'h8) ?
                                   hex_chr(4'(s.ret >> (5'h1c -
                                   {s.rep_idx[2:0], 2'b00}))) :
                                   (s.rep_idx == 4'h8) ? `SCITB_CH_CR :
                                   `SCITB_CH_LF};
                end
            end
            default:
                n.state = scitb_pkg::ST_NAME;
        endcase

        // Watchdog: due after the period, sent only between host frames.
        no_wd = (s.state == scitb_pkg::ST_SPI &&
                 s.cmd == scitb_pkg::CMD_SPIR);
        if (!wd_enable_i)
        begin
            n.wd_due = 1'b0;
            n.wd_ms = 16'h0000;
        end
        else if (ms_tick && !s.wd_due)
        begin
            n.wd_ms = s.wd_ms + 16'h0001;
            if (s.wd_ms + 16'h0001 >= wd_period_i)
            begin
                n.wd_due = 1'b1;
                n.wd_ms = 16'h0000;
            end
        end
        if (s.wd_due && wd_enable_i && !spi_busy && !s.wd_run &&
            !host_go && !no_wd)
        begin
            wd_go = 1'b1;
            n.wd_run = 1'b1;
            n.wd_due = 1'b0;
        end
        else if (s.wd_run && spi_done)
            n.wd_run = 1'b0;
        if (spi_done)
            n.last_rx = spi_rx;
    end

    // ------------------------------------------------------------------
    // Registers and SPI engine
    // ------------------------------------------------------------------

    // State register; the UART line idles high.
    always_ff @(posedge ref_clk_i)
    begin
        if (reset_i)
        begin
            s <= '0;
            s.txd <= 1'b1;
            s.rx_m <= 1'b1;
            s.rx_s <= 1'b1;
        end
        else
        begin
            s <= n;
        end
    end

    // Words go out unchanged; any check bits are the host's.
    always_comb
    begin
        req.start = host_go | wd_go;
        req.slot = s.arg[0][1:0];
        req.wide = spi_wide_i[s.arg[0][1:0]];
        req.word = wd_go ? wd_word_i : (s.step ? s.arg[3] : s.arg[2]);
    end

    scitb_spi u_spi
    (
        .ref_clk_i(ref_clk_i),
        .reset_i(reset_i),
        .req_i(req),
        .miso_i(spi_miso_i),
        .pins_o(spi_pins_o),
        .busy_o(spi_busy),
        .done_o(spi_done),
        .rx_o(spi_rx)
    );

    assign uart_txd_o = s.txd;
    assign io_out_o = s.io_out;
    assign io_oe_o = s.io_oe;
    assign cmd_busy_o = (s.state != scitb_pkg::ST_NAME &&
                         s.state != scitb_pkg::ST_ARGS);

endmodule

/* tb/scitb_props.sv */
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Port checks for the command bridge.
// ----------------------------------------------------------------
module scitb_props
(
    input wire logic ref_clk_i,
    input wire logic reset_i,
    input wire logic uart_txd_o,
    input wire logic [31:0] io_out_o,
    input wire logic [31:0] io_oe_o,
    input scitb_pkg::scitb_spi_pins_t spi_pins_o,
    input wire logic cmd_busy_o
);
    // One clock domain; checks pause while reset is high.
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (reset_i);
    // A reply character opens with a start bit that stands.
    sequence s_start;
        $fell(uart_txd_o);
    endsequence
    sequence s_start_held;
        !uart_txd_o [*8];
    endsequence
    chk_reset_idle: assert property ($fell(reset_i) |-> uart_txd_o
        && io_oe_o == 32'h0 && io_out_o == 32'h0 && !cmd_busy_o
        && spi_pins_o.cs_n == 4'hf) else $error("not idle after reset");
    chk_start_bit: assert property (s_start |-> s_start_held)
        else $error("start bit too short");
    chk_idle_high: assert property (!cmd_busy_o |-> uart_txd_o)
        else $error("transmit active while idle");
    chk_oe_sticky: assert property (
        (io_oe_o & $past(io_oe_o)) == $past(io_oe_o))
        else $error("driven line released");
    chk_out_busy: assert property (!$stable(io_out_o) |-> cmd_busy_o)
        else $error("line changed with no command");
    chk_out_driven: assert property (
        ((io_out_o ^ $past(io_out_o)) & ~io_oe_o) == 32'h0)
        else $error("undriven line changed");
    chk_cs_single: assert property (
        $countones(~spi_pins_o.cs_n) <= 1) else $error("two targets");
    chk_sclk_idle: assert property (
        &spi_pins_o.cs_n |-> !spi_pins_o.sclk) else $error("stray clock");
endmodule
bind scitb_top scitb_props i_scitb_props
(
    .ref_clk_i(ref_clk_i), .reset_i(reset_i), .uart_txd_o(uart_txd_o),
    .io_out_o(io_out_o), .io_oe_o(io_oe_o), .spi_pins_o(spi_pins_o),
    .cmd_busy_o(cmd_busy_o)
);

/* tb/scitb_host.sv */
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Host terminal: frames command bytes, gathers reply bytes.
// ----------------------------------------------------------------
module scitb_host
#(
    parameter int BIT = 173
)
(
    input wire logic clk_i,
    input wire logic rxd_i,
    output logic txd_o
);
    logic [7:0] rxq [$];
    logic [7:0] b;
    // The line idles high.
    initial txd_o = 1'h1;
    // Start, eight data bits LSB first, stop; BIT clocks each.
    task automatic send(input logic [7:0] c);
        logic [9:0] f;
        f = {1'h1, c, 1'h0};
        @(posedge clk_i);
        for (int i = 0; i < 10; i++)
        begin
            #1 txd_o = f[i];
            repeat (BIT) @(posedge clk_i);
        end
    endtask
    // Each reply bit is sampled at its middle.
    always
    begin
        @(negedge rxd_i);
        repeat (BIT / 2) @(posedge clk_i);
        for (int i = 0; i < 8; i++)
        begin
            repeat (BIT) @(posedge clk_i);
            b[i] = rxd_i;
        end
        rxq.push_back(b);
    end
endmodule

/* tb/tb_serial_command_test_bridge.sv */
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Bench: text commands in, reply lines out, model compared.
// ----------------------------------------------------------------
module tb_serial_command_test_bridge;
    logic clk = 1'h0;
    logic rst = 1'h1;
    logic rxd, txd, busy, miso, wd_en;
    logic [31:0] io_in, io_out, io_oe, wd_word;
    logic [15:0] wd_per;
    logic [3:0] wide;
    scitb_pkg::scitb_spi_pins_t pins;
    int n_errors = 0;
    int n_compared = 0;
    int lvl [32] = '{default: -1};
    int l;
    // Free-running 20 MHz clock.
    always #25 clk = ~clk;
    scitb_top #(.MS_CYCLES(20), .BAUD_CYCLES(20)) i_scitb_top (
        .ref_clk_i(clk), .reset_i(rst),
        .uart_rxd_i(rxd), .uart_txd_o(txd), .io_in_i(io_in),
        .io_out_o(io_out), .io_oe_o(io_oe), .spi_wide_i(wide),
        .spi_miso_i(miso), .spi_pins_o(pins), .wd_enable_i(wd_en),
        .wd_period_i(wd_per), .wd_word_i(wd_word), .cmd_busy_o(busy));
    scitb_host #(.BIT(20)) i_scitb_host (.clk_i(clk), .rxd_i(txd),
        .txd_o(rxd));
    // The SPI target loops back: each frame answers with its own word.
    assign miso = pins.mosi;
    // Counts, verdict and end of run.
    task automatic print_verdict();
        $display("compared %0d, mismatches %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    // One counted comparison.
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            n_errors++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    // Reply line the model expects for a value.
    function automatic string line(int v);
        return $sformatf("%08x\015\n", v);
    endfunction
    // Send one command, wait for its whole reply, compare it.
    task automatic run(input string s, input string e);
        i_scitb_host.rxq.delete();
        for (int i = 0; i < s.len(); i++)
            i_scitb_host.send(s[i]);
        for (int t = 0; t < 40000; t++)
            if (i_scitb_host.rxq.size() < e.len() || busy !== 1'h0)
                @(posedge clk);
        if (i_scitb_host.rxq.size() < e.len() || busy !== 1'h0)
        begin
            cmp(0, 1);
            print_verdict();
        end
        for (int i = 0; i < e.len(); i++)
            cmp(i_scitb_host.rxq[i], e[i]);
        $display("test %s done", s);
    endtask
    // Main sequence: write, read back a random line, refused slot.
    initial
    begin
        void'($urandom(10180));
        io_in = $urandom();
        wd_word = $urandom();
        wd_per = 16'($urandom_range(2));
        wide = 4'($urandom());
        wd_en = 1'h0;
        l = $urandom_range(7);
        repeat (10) @(posedge clk);
        #1 rst = 1'h0;
        lvl[11] = 1;
        run("iow(1,3,1)", line(1));
        cmp(io_out[11], 1'h1);
        cmp(io_oe[11], 1'h1);
        run($sformatf("ior(1,%0h)", l),
            line(lvl[8 + l] < 0 ? io_in[8 + l] : lvl[8 + l]));
        run("iow(4,0,1)", "?\015\n");
        cmp(io_oe, 32'h800);
        run("iop(1,3,1,2)", line(3));
        cmp(io_out[11], 1'h0);
        run("iowt(1,3,0)", line(0));
        run("help()", line(0));
        run("delay(3)", line(3));
        run("spi(0,0,0a5c3)", line(0));
        run("spir(0,0,1234,0beef0)",
            line(wide[0] ? 32'hbeef0 : 32'heef0));
        #1 wd_en = 1'h1;
        run($sformatf("spis(0,0,0%0h,6,2)", wd_word),
            line(wide[0] ? wd_word : wd_word[15:0]));
        print_verdict();
    end
endmodule
